// ---- rtl/buck_fault_regs.vh ----
// Offsets, field positions, reset values and timing counts of the buck fault sequencer
`ifndef BUCK_FAULT_REGS_VH
`define BUCK_FAULT_REGS_VH

// Register byte offsets
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_IRQ_STATUS  8'h08
`define REG_IRQ_MASK    8'h0c
`define REG_RAMP_LEN    8'h10

// Control fields
`define CTRL_SW_EN      0
`define CTRL_RESET      32'h0000_0001

// Event bits (interrupt status and mask share this layout)
`define EV_LIMIT        0
`define EV_OVERLOAD     1
`define EV_LATCHOFF     2
`define EV_OVP          3
`define EV_THERMAL      4
`define EV_PGOOD_LOST   5
`define EV_WIDTH        6
`define MASK_RESET      6'h00

// Overload counting
`define WINDOW_CYCLES   8'h80
`define LIMIT_TRIP      7'h40
`define DUMMY_RAMPS     2'h3
`define HICCUP_TRIES    4'h7

// Ramp length register reset value; stored and read back only, no ramp logic uses it
`define RAMP_LEN_RESET  16'h0040

// Dead time
`define DEAD_NS         8'h1e
`define CLK_NS          8'h08

`endif

// ---- rtl/dead_time_gen.v ----
// Non-overlapping gate drive pair with fixed dead time
`timescale 1ns/1ps
`default_nettype none
`include "buck_fault_regs.vh"

module dead_time_gen (
   input  wire       clk,
   input  wire       resetn,
   input  wire       wantHigh,
   input  wire       wantLow,
   output reg        highGate,
   output reg        lowGate
);

   // Least time rounds up to whole cycles
   localparam [7:0] DEAD_FULL   = (`DEAD_NS + `CLK_NS - 8'h01) / `CLK_NS;
   localparam [2:0] DEAD_CYCLES = DEAD_FULL[2:0];

   reg  [2:0] deadCount;

   always @(posedge clk) begin
      if (!resetn) begin
         highGate  <= 1'b0;
         lowGate   <= 1'b0;
         deadCount <= 3'h0;
      end else begin
         // Turn-off is immediate, turn-on waits the dead time [R16]
         if (!wantHigh)
            highGate <= 1'b0;
         if (!wantLow)
            lowGate <= 1'b0;
         if ((highGate && !wantHigh) || (lowGate && !wantLow))
            deadCount <= DEAD_CYCLES;
         else if (deadCount != 3'h0)
            deadCount <= deadCount - 3'h1;
         if (deadCount == 3'h0 && !highGate && !lowGate) begin
            if (wantHigh && !wantLow)
               highGate <= 1'b1;
            else if (wantLow && !wantHigh)
               lowGate <= 1'b1;
         end
      end
   end

endmodule // dead_time_gen

`default_nettype wire

// ---- rtl/buck_fault_sequencer.v ----
// Overload, hiccup, power-good, crowbar and thermal sequencer of a buck controller
//
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "buck_fault_regs.vh"

// Function
// R1: Current-limit in a cycle turns high-side drive off for rest of cycle.
// R2: Select input high enables hiccup instead of immediate latch-off.
// R3: Hiccup starts when 64 limit pulses occur within 128 oscillator cycles.
// R4: Limit pulse counter clears at end of every 128-cycle period.
// R5: Each hiccup is three dummy ramps: rise to full level, discharge below start.
// R6: Hiccup repeats seven times; still overloaded on eighth attempt latches off.
// R7: Latch-off clears only at power-on reset.
// R8: During hiccup ramps switch high side only, low side held off.
// R9: Select input low: 64 of 128 pulses pulls soft-start low and latches off.
// R10: Board ties select input to supply or ground, never floating.
// R11: Power-good pulled low when feedback above 0.55V or below 0.45V.
// R12: Power-good held low until soft-start reaches 2V.
// R13: Overvoltage above 0.5V holds low-side drive continuously on.
// R14: Die above about 150 degrees shuts both gate drives off.
// R15: Low side off in startup until soft-start 2V, then synchronous switching.
// R16: About 30 ns dead time between one driver off and other on; code gives 5 clocks of 8 ns, 40 ns.
// R17: Soft-start node below 0.5V disables switching entirely.
// R18: Analog comparator results synchronised to oscillator clock before use.
module buck_fault_sequencer (
   input  wire        clk,
   input  wire        resetn,
   input  wire        pwmHigh,
   input  wire        currentLimit,
   input  wire        overloadResponseSelect,
   input  wire        feedbackHigh,
   input  wire        feedbackLow,
   input  wire        overvoltageSense,
   input  wire        overTemperature,
   input  wire        softstartShutdownNode,
   input  wire        softstartStartLevel,
   input  wire        softstartFullLevel,
   output wire        highSideGateDrive,
   output wire        lowSideGateDrive,
   output reg         softstartDischarge,
   output reg         powerGoodOut,
   output wire        powerGoodOutEn,
   output wire        irq,
   input  wire [31:0] wb_adr_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   input  wire [3:0]  wb_sel_i,
   input  wire        wb_we_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   output reg         wb_ack_o
);

   localparam [4:0] ST_RUN    = 5'h01;
   localparam [4:0] ST_DISCH  = 5'h02;
   localparam [4:0] ST_RAMP   = 5'h04;
   localparam [4:0] ST_LATCH  = 5'h08;
   localparam [4:0] ST_WAIT   = 5'h10;

   // Pin synchronisers, first stage read only by second [R18]
   reg  [8:0]  syncA;
   reg  [8:0]  syncB;
   wire [8:0]  rawIn = {softstartFullLevel, softstartStartLevel, softstartShutdownNode,
                        overTemperature, overvoltageSense, feedbackLow, feedbackHigh,
                        overloadResponseSelect, currentLimit};

   always @(posedge clk) begin
      if (!resetn) begin
         syncA <= 9'h000;
         syncB <= 9'h000;
      end else begin
         syncA <= rawIn;
         syncB <= syncA;
      end
   end

   wire limitS    = syncB[0];
   wire hiccupSel = syncB[1];
   wire fbHighS   = syncB[2];
   wire fbLowS    = syncB[3];
   wire ovpS      = syncB[4];
   wire hotS      = syncB[5];
   wire ssAbove   = syncB[6];
   wire ssStart   = syncB[7];
   wire ssFull    = syncB[8];

   reg  [31:0] ctrl;
   reg  [`EV_WIDTH-1:0] irqStatus;
   reg  [`EV_WIDTH-1:0] irqMask;
   reg  [15:0] rampLen;
   reg  [4:0]  state;
   reg  [7:0]  periodCount;
   reg  [6:0]  limitCount;
   reg         limitPrev;
   reg         limitHold;
   reg         pwmPrev;
   reg  [1:0]  rampCount;
   reg  [3:0]  tryCount;
   reg         startupDone;
   reg         pgPrev;

   wire limitRise = limitS && !limitPrev;
   wire cycleStart = pwmHigh && !pwmPrev;
   wire [6:0] limitNext = limitCount + {6'h00, limitRise};
   wire periodEnd = (periodCount == (`WINDOW_CYCLES - 8'h01));
   wire tripNow = (limitNext >= `LIMIT_TRIP) && (state == ST_RUN);

   // Oscillator cycle = rising pwm edge; 128-cycle counting period [R4]
   always @(posedge clk) begin
      if (!resetn) begin
         periodCount <= 8'h00;
         limitCount  <= 7'h00;
         limitPrev   <= 1'b0;
         pwmPrev     <= 1'b0;
         limitHold   <= 1'b0;
      end else begin
         limitPrev <= limitS;
         pwmPrev   <= pwmHigh;
         if (cycleStart) begin
            limitHold <= limitRise; // Set wins over cycle restart [R1]
            if (periodEnd) begin
               periodCount <= 8'h00;
               limitCount  <= 7'h00; // [R4]
            end else begin
               periodCount <= periodCount + 8'h01;
               limitCount  <= tripNow ? 7'h00 : limitNext;
            end
         end else begin
            if (limitRise)
               limitHold <= 1'b1; // [R1]
            limitCount <= tripNow ? 7'h00 : limitNext;
         end
      end
   end

   // Overload sequencer; latch leaves only through resetn (power-on) [R7]
   always @(posedge clk) begin
      if (!resetn) begin
         state              <= ST_RUN;
         rampCount          <= 2'h0;
         tryCount           <= 4'h0;
         softstartDischarge <= 1'b0;
      end else begin
         case (state)
            ST_RUN: begin
               softstartDischarge <= 1'b0;
               if (tripNow) begin
                  if (hiccupSel && tryCount < `HICCUP_TRIES) begin // [R2] [R3]
                     tryCount  <= tryCount + 4'h1;
                     rampCount <= 2'h0;
                     state     <= ST_DISCH;
                  end else begin
                     state <= ST_LATCH; // [R6] [R9]
                  end
               end
            end
            ST_DISCH: begin
               softstartDischarge <= 1'b1;
               if (!ssStart)
                  state <= ST_RAMP;
            end
            ST_RAMP: begin
               softstartDischarge <= 1'b0;
               if (ssFull) begin // [R5]
                  if (rampCount == `DUMMY_RAMPS - 2'h1) begin
                     state <= ST_WAIT;
                  end else begin
                     rampCount <= rampCount + 2'h1;
                     state     <= ST_DISCH;
                  end
               end
            end
            ST_WAIT: begin
               state <= ST_RUN;
            end
            ST_LATCH: begin
               softstartDischarge <= 1'b1; // [R9]
            end
            default: begin
               state <= ST_LATCH;
            end
         endcase
      end
   end

   // Startup completes at 2V; hiccup ramps clear it again
   always @(posedge clk) begin
      if (!resetn)
         startupDone <= 1'b0;
      else if (state != ST_RUN || !ssAbove)
         startupDone <= 1'b0;
      else if (ssFull)
         startupDone <= 1'b1; // [R15]
   end

   wire switching = ssAbove && ssStart && !hotS && ctrl[`CTRL_SW_EN]
                    && (state == ST_RUN || state == ST_RAMP); // [R17]
   wire wantHigh = switching && pwmHigh && !limitHold && !limitRise && !ovpS; // [R1]
   wire syncOk = startupDone && state == ST_RUN; // [R8] [R15]
   wire wantLow = !hotS && (ovpS || (switching && syncOk && !pwmHigh)); // [R13] [R14]

   dead_time_gen u_dead (
      .clk      (clk),
      .resetn   (resetn),
      .wantHigh (wantHigh),
      .wantLow  (wantLow),
      .highGate (highSideGateDrive),
      .lowGate  (lowSideGateDrive)
   );

   // Open drain: enable low pulls pin low [R11] [R12]
   wire pgBad = fbHighS || fbLowS || !startupDone;
   always @(posedge clk) begin
      if (!resetn)
         powerGoodOut <= 1'b0;
      else
         powerGoodOut <= !pgBad;
   end
   assign powerGoodOutEn = powerGoodOut;

   // Event capture, set wins over write-one-to-clear
   wire [`EV_WIDTH-1:0] events;
   assign events[`EV_LIMIT]      = limitRise;
   assign events[`EV_OVERLOAD]   = tripNow;
   assign events[`EV_LATCHOFF]   = (state == ST_LATCH);
   assign events[`EV_OVP]        = ovpS;
   assign events[`EV_THERMAL]    = hotS;
   assign events[`EV_PGOOD_LOST] = pgPrev && !powerGoodOut;

   wire wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wbWr  = wbHit && wb_we_i && wb_sel_i[0];
   wire [7:0] addr = wb_adr_i[7:0];

   genvar gi;
   generate
      for (gi = 0; gi < `EV_WIDTH; gi = gi + 1) begin : g_ev
         always @(posedge clk) begin
            if (!resetn)
               irqStatus[gi] <= 1'b0;
            else if (events[gi])
               irqStatus[gi] <= 1'b1;
            else if (wbWr && addr == `REG_IRQ_STATUS && wb_dat_i[gi])
               irqStatus[gi] <= 1'b0;
         end
      end
   endgenerate

   assign irq = |(irqStatus & irqMask);

   // Wishbone slave, one-cycle ack registered one cycle after the strobe
   always @(posedge clk) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         ctrl     <= `CTRL_RESET;
         irqMask  <= `MASK_RESET;
         rampLen  <= `RAMP_LEN_RESET;
         pgPrev   <= 1'b0;
      end else begin
         pgPrev   <= powerGoodOut;
         wb_ack_o <= wbHit;
         if (wbWr) begin
            case (addr)
               `REG_CTRL:     ctrl[0] <= wb_dat_i[0];
               `REG_IRQ_MASK: irqMask <= wb_dat_i[`EV_WIDTH-1:0];
               `REG_RAMP_LEN: rampLen <= wb_dat_i[15:0];
               default:       ctrl <= ctrl;
            endcase
         end
         if (wbHit && !wb_we_i) begin
            case (addr)
               `REG_CTRL:       wb_dat_o <= ctrl;
               `REG_STATUS:     wb_dat_o <= {17'h00000, tryCount, 1'b0, rampCount,
                                             state, startupDone, hiccupSel,
                                             powerGoodOut};
               `REG_IRQ_STATUS: wb_dat_o <= {26'h0000000, irqStatus};
               `REG_IRQ_MASK:   wb_dat_o <= {26'h0000000, irqMask};
               `REG_RAMP_LEN:   wb_dat_o <= {16'h0000, rampLen};
               default:         wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule // buck_fault_sequencer

`default_nettype wire

// ---- test/buck_asserts.sv ----
// Port assertions for the buck fault sequencer
`timescale 1ns/1ps
`default_nettype none
module buck_asserts (
   input wire logic clk,
   input wire logic resetn,
   input wire logic currentLimit,
   input wire logic overvoltageSense,
   input wire logic overTemperature,
   input wire logic feedbackHigh,
   input wire logic feedbackLow,
   input wire logic softstartFullLevel,
   input wire logic highSideGateDrive,
   input wire logic lowSideGateDrive,
   input wire logic powerGoodOut,
   input wire logic softstartDischarge,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Repeat counts leave room for the two-flop sync and output register
   a_limit_cuts_high: assert property (currentLimit[*5] |-> !highSideGateDrive)
      else $error("high side on under limit");
   a_no_overlap: assert property (($fell(highSideGateDrive) || $fell(lowSideGateDrive))
      |-> (!highSideGateDrive && !lowSideGateDrive)[*3]) else $error("gate overlap");
   a_thermal_off: assert property (overTemperature[*5] |-> !highSideGateDrive
      && !lowSideGateDrive) else $error("gates on while hot");
   a_ovp_crowbar: assert property ((overvoltageSense && !overTemperature)[*8]
      |=> lowSideGateDrive) else $error("no crowbar");
   a_pg_window: assert property ((feedbackHigh || feedbackLow)[*4] |-> !powerGoodOut)
      else $error("power good out of window");
   a_pg_startup: assert property (!softstartFullLevel[*4] ##0 !powerGoodOut
      |=> !powerGoodOut) else $error("power good before startup");
   // Power good low marks startup or hiccup; a later sag of the node is not startup
   a_async_start: assert property ((!softstartFullLevel && !overvoltageSense
      && !powerGoodOut)[*8] |-> !lowSideGateDrive) else $error("low side on during ramp");
   a_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bad ack");
   c_hiccup: cover property (softstartDischarge);
   c_crowbar: cover property (overvoltageSense && lowSideGateDrive);
   c_pg_lost: cover property ($fell(powerGoodOut));
endmodule // buck_asserts
bind buck_fault_sequencer buck_asserts buck_asserts_i (.clk, .resetn, .currentLimit,
   .overvoltageSense, .overTemperature, .feedbackHigh, .feedbackLow, .softstartFullLevel,
   .highSideGateDrive, .lowSideGateDrive, .powerGoodOut, .softstartDischarge, .wb_cyc_i,
   .wb_stb_i, .wb_ack_o);
`default_nettype wire

// ---- test/power_stage_model.sv ----
// Far side: soft-start capacitor and current-sense comparator
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
   input  wire logic clk,
   input  wire logic pwmHigh,
   input  wire logic highSideGateDrive,
   input  wire logic softstartDischarge,
   input  wire logic overload,
   input  wire logic holdLow,
   output var  logic currentLimit,
   output wire logic ssAboveOff,
   output wire logic ssAboveStart,
   output wire logic ssFull
);
   logic [5:0] ssLevel = 6'h00;
   logic       prevPwm = 1'b0;
   initial currentLimit = 1'b0;
   // Sink outpaces the charge current
   always @(posedge clk) begin
      prevPwm <= pwmHigh;
      if (holdLow || softstartDischarge)
         ssLevel <= (ssLevel > 6'h02) ? ssLevel - 6'h02 : 6'h00;
      else if (ssLevel < 6'h28)
         ssLevel <= ssLevel + 6'h01;
      // Comparator stays tripped until the next cycle starts
      if (pwmHigh && !prevPwm)
         currentLimit <= 1'b0;
      else if (overload && highSideGateDrive)
         currentLimit <= 1'b1;
   end
   assign ssAboveOff   = ssLevel > 6'h05;
   assign ssAboveStart = ssLevel > 6'h0a;
   assign ssFull       = ssLevel >= 6'h14;
endmodule // power_stage_model
`default_nettype wire

// ---- test/buck_fault_sequencer_tb.sv ----
// Self-checking bench of the buck fault sequencer
`timescale 1ns/1ps
`default_nettype none
`include "buck_fault_regs.vh"
module buck_fault_sequencer_tb;
   logic        clk = 1'b0, resetn = 1'b0, pwm = 1'b0, load = 1'b0, hold = 1'b0;
   logic        select = 1'b1, fbHi = 1'b0, fbLo = 1'b0, overvoltage_sense = 1'b0, hot = 1'b0;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, prevFull = 1'b0;
   logic [3:0]  sel = 4'h0, phase = 4'h0;
   logic [31:0] adr = 32'h0, wdat = 32'h0, q;
   wire         lim, ssOn, ssStart, ssFull, hi, lo, dis, pg, pgEn, irq, ack;
   wire  [31:0] rdat;
   int          ramps = 0, cycles = 0, errorCnt = 0, checkCount = 0;
   always #4 clk = ~clk;
   always @(posedge clk) begin
      phase <= phase + 4'h1;
      // Low phase outlasts the dead time, else the low side never switches
      pwm <= phase < 4'h8;
      prevFull <= ssFull;
      if (ssFull && !prevFull)
         ramps <= ramps + 1;
      cycles <= cycles + 1;
      // Eight overload windows plus ramps fit well inside this
      if (cycles == 80000) begin
         errorCnt++;
         conclude();
      end
   end
   buck_fault_sequencer buck_fault_sequencer_i (
      .clk(clk), .resetn(resetn), .pwmHigh(pwm), .currentLimit(lim),
      .overloadResponseSelect(select), .feedbackHigh(fbHi), .feedbackLow(fbLo),
      .overvoltageSense(overvoltage_sense), .overTemperature(hot), .softstartShutdownNode(ssOn),
      .softstartStartLevel(ssStart), .softstartFullLevel(ssFull), .highSideGateDrive(hi),
      .lowSideGateDrive(lo), .softstartDischarge(dis), .powerGoodOut(pg),
      .powerGoodOutEn(pgEn), .irq(irq), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack));
   power_stage_model power_stage_model_i (
      .clk(clk), .pwmHigh(pwm), .highSideGateDrive(hi), .softstartDischarge(dis),
      .overload(load), .holdLow(hold), .currentLimit(lim), .ssAboveOff(ssOn),
      .ssAboveStart(ssStart), .ssFull(ssFull));
   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         errorCnt++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic w,
                       input logic [3:0] s);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= s;
      adr <= {24'h0, a};
      wdat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, d, 1'b1, 4'hf);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
      xfer(a, 32'h0, 1'b0, 4'hf);
      check(n, q, e);
   endtask
   task automatic state(input logic [4:0] e);
      xfer(`REG_STATUS, 32'h0, 1'b0, 4'hf);
      check("state", q[7:3], e);
   endtask
   task automatic hiccupRun;
      wr(`REG_IRQ_MASK, 32'h1 << `EV_LATCHOFF);
      wr(`REG_IRQ_STATUS, 32'h3f);
      ramps = 0;
      load <= 1'b1;
      wait (irq === 1'b1);
      repeat (2) @(posedge clk);
   endtask
   task automatic conclude;
      if (errorCnt == 0 && checkCount > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      check("reset outputs", {hi, lo, dis, pg, irq, ack}, 32'h0);
      resetn <= 1'b1;
      rd(`REG_CTRL, `CTRL_RESET, "ctrl");
      rd(`REG_IRQ_MASK, `MASK_RESET, "mask");
      xfer(`REG_RAMP_LEN, 32'h1234, 1'b1, 4'h0);
      rd(`REG_RAMP_LEN, `RAMP_LEN_RESET, "ramp len");
      wr(`REG_RAMP_LEN, 32'h1234);
      rd(`REG_RAMP_LEN, 32'h1234, "ramp len");
      wr(8'h14, 32'hffff);
      rd(8'h14, 32'h0, "unmapped");
      wait (pg === 1'b1);
      check("full at power good", ssFull, 1'b1);
      wait (lo === 1'b1);
      check("full at sync start", ssFull, 1'b1);
      wr(`REG_IRQ_MASK, 32'h3f);
      for (int k = 0; k < 3; k++) begin
         if (k == 2)
            wr(`REG_IRQ_MASK, 32'h0);
         wr(`REG_IRQ_STATUS, 32'h3f);
         fbHi <= k == 0;
         fbLo <= k != 0;
         repeat (6) @(posedge clk);
         check("window", {pg, pgEn, irq}, {2'b00, k < 2});
         rd(`REG_IRQ_STATUS, 32'h1 << `EV_PGOOD_LOST, "pgood lost");
         fbHi <= 1'b0;
         fbLo <= 1'b0;
         wait (pg === 1'b1);
      end
      overvoltage_sense <= 1'b1;
      repeat (12) @(posedge clk);
      check("crowbar", {hi, lo}, 2'b01);
      hot <= 1'b1;
      repeat (6) @(posedge clk);
      check("thermal", {hi, lo}, 2'b00);
      overvoltage_sense <= 1'b0;
      hot <= 1'b0;
      hold <= 1'b1;
      repeat (40) @(posedge clk);
      check("shutdown", {hi, lo, pg}, 3'b000);
      hold <= 1'b0;
      wait (pg === 1'b1);
      hiccupRun();
      check("dummy ramps", ramps, 21);
      state(5'h08);
      load <= 1'b0;
      wr(`REG_CTRL, `CTRL_RESET);
      repeat (300) @(posedge clk);
      check("latched", {hi, lo, pg}, 3'b000);
      state(5'h08);
      resetn <= 1'b0;
      select <= 1'b0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      wait (pg === 1'b1);
      state(5'h01);
      hiccupRun();
      check("no hiccup", {ramps[3:0], dis}, 5'h01);
      state(5'h08);
      conclude();
   end
endmodule // buck_fault_sequencer_tb
`default_nettype wire
